// file: core/ppi_defines.svh
`ifndef PPI_DEFINES_SVH
`define PPI_DEFINES_SVH
// Port select codes
`define SEL_FIRST 2'b00
`define SEL_SECOND 2'b01
`define SEL_THIRD 2'b10
`define SEL_CTRL 2'b11
// Control word fields
`define CW_MODE_DEF 7
`define CW_A_MODE_HI 6
`define CW_A_MODE_LO 5
`define CW_A_IN 4
`define CW_CU_IN 3
`define CW_B_MODE 2
`define CW_B_IN 1
`define CW_CL_IN 0
`define BSR_IDX_HI 3
`define BSR_IDX_LO 1
`define BSR_VAL 0
// Third port handshake bit positions
`define TP_IRQ_B 0
`define TP_FLAG_B 1
`define TP_LOAD_B 2
`define TP_IRQ_A 3
`define TP_LOAD_A 4
`define TP_INFULL_A 5
`define TP_ACK_A 6
`define TP_OUTFULL_A 7
// Reset values and sizes
`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hFF
`define SYNC_RESET 37'h1F_FFFF_FFFF
`define FIFO_DEPTH 4
`endif

// file: core/ppi_pkg.sv
package ppi_pkg;
    typedef enum logic {MODE_BASIC, MODE_STROBED} mode_t;
    typedef struct packed {
        mode_t a_mode;
        logic a_in;
        logic cu_in;
        mode_t b_mode;
        logic b_in;
        logic cl_in;
    } ctrl_t;
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [1:0] sel;
        logic [7:0] data;
        logic [7:0] pa;
        logic [7:0] pb;
        logic [7:0] pc;
    } pins_t;
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] data;
    } cmd_t;
    typedef struct packed {
        logic [7:0] latch_in;
        logic full;
        logic irq;
        logic mask;
    } group_t;
    typedef struct packed {
        logic [7:0] val;
        logic [7:0] oe_n;
    } drive_t;
    typedef struct packed {
        pins_t s1;
        pins_t s2;
        pins_t s3;
        pins_t filt;
        pins_t prev;
        logic wr_live;
        cmd_t wcmd;
        logic [1:0] rd_sel;
        ctrl_t ctrl;
        logic [7:0] pa_latch;
        logic [7:0] pb_latch;
        logic [7:0] pc_latch;
        group_t [1:0] grp;
        drive_t pa_drv;
        drive_t pb_drv;
        drive_t pc_drv;
        logic [7:0] bus_out;
        logic bus_oe_n;
        logic fifo_full;
    } top_state_t;
endpackage

// file: core/programmable_parallel_port.sv
// Function
// - Control word location is never read back
// - Reset sets control to basic mode, all 24 lines input
// - Input mode holds until a mode write
// - Group A: first port, upper third nibble
// - Third port latched out, unlatched in
// - Mode write clears all outputs and flags
// - Bit write changes one third-port bit
// - Basic mode direction bits, 1 is input
// - Basic mode: latched out, direct in
// - Request gated by mask, set by bit write
// - Masks cleared by mode write and reset
// - Strobed group: data port plus nibble
// - Low load strobe latches port lines
// - Input full set by strobe, cleared read
// - Input request set, cleared by read fall
// - Input masks: bit 4 and bit 2
// - Output full set by write, cleared ack
// - Output request set, cleared by write fall
// - Output masks: bit 6 and bit 2
// - Select lines pick port or control word
`timescale 1ns/1ps
`include "ppi_defines.svh"

module cmd_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    // Pointers wrap by overflow, so DEPTH must be a power of two
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_state_t;
    fifo_state_t fs_ff;
    fifo_state_t nxt_fs;
    logic push;
    logic pop;

    assign in_ready = fs_ff.cnt != FULL_COUNT;
    assign out_valid = fs_ff.cnt != '0;
    assign out_data = fs_ff.mem[fs_ff.rp];

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        nxt_fs = fs_ff;
        if (push) begin
            nxt_fs.mem[fs_ff.wp] = in_data;
            nxt_fs.wp = fs_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_fs.rp = fs_ff.rp + 1'b1;
        end
        if (push && !pop) begin
            nxt_fs.cnt = fs_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_fs.cnt = fs_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fs_ff <= '0;
        end else begin
            fs_ff <= nxt_fs;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

module programmable_parallel_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Host bus
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [1:0] port_select_lines,
    input wire logic [7:0] host_bus_lines_in,
    output logic [7:0] host_bus_lines_out,
    output logic host_bus_lines_oe_n,
    // First port
    input wire logic [7:0] first_port_lines_in,
    output logic [7:0] first_port_lines_out,
    output logic [7:0] first_port_lines_oe_n,
    // Second port
    input wire logic [7:0] second_port_lines_in,
    output logic [7:0] second_port_lines_out,
    output logic [7:0] second_port_lines_oe_n,
    // Third port
    input wire logic [7:0] third_port_lines_in,
    output logic [7:0] third_port_lines_out,
    output logic [7:0] third_port_lines_oe_n,
    // Write buffer status
    output logic cmd_fifo_full
);
    localparam ppi_pkg::top_state_t RESET_ST = '{
        s1: `SYNC_RESET,
        s2: `SYNC_RESET,
        s3: `SYNC_RESET,
        filt: `SYNC_RESET,
        prev: `SYNC_RESET,
        wr_live: 1'b0,
        wcmd: '0,
        rd_sel: `SEL_FIRST,
        ctrl: '{a_mode: ppi_pkg::MODE_BASIC, a_in: 1'b1, cu_in: 1'b1,
                b_mode: ppi_pkg::MODE_BASIC, b_in: 1'b1, cl_in: 1'b1},
        pa_latch: `BYTE_ZERO,
        pb_latch: `BYTE_ZERO,
        pc_latch: `BYTE_ZERO,
        grp: '0,
        pa_drv: '{val: `BYTE_ZERO, oe_n: `BYTE_ONES},
        pb_drv: '{val: `BYTE_ZERO, oe_n: `BYTE_ONES},
        pc_drv: '{val: `BYTE_ZERO, oe_n: `BYTE_ONES},
        bus_out: `BYTE_ZERO,
        bus_oe_n: 1'b1,
        fifo_full: 1'b0
    };

    ppi_pkg::top_state_t st_ff, nxt_st;
    ppi_pkg::pins_t pin_vec, f, p;
    ppi_pkg::cmd_t exec_cmd;
    logic exec_valid, exec_ready, fifo_in_ready;
    logic rd_act, rd_fall, rd_rise, wr_fall, wr_rise;
    logic exec_mode, exec_bsr;
    logic [2:0] bsr_idx;
    logic [7:0] bsr_bit;
    logic [2:0] mask_idx_a;
    logic [1:0] strobed, is_in, stb;

    assign pin_vec = {cs_n, rd_n, wr_n, port_select_lines, host_bus_lines_in,
                      first_port_lines_in, second_port_lines_in, third_port_lines_in};
    assign f = st_ff.filt;
    assign p = st_ff.prev;
    assign rd_act = !f.cs_n && !f.rd_n;
    assign rd_fall = rd_act && p.rd_n;
    assign rd_rise = f.rd_n && !p.rd_n && !p.cs_n;
    assign wr_fall = !f.cs_n && !f.wr_n && p.wr_n;
    assign wr_rise = f.wr_n && !p.wr_n && st_ff.wr_live;
    // Drain stalls during a host read so the byte on the bus stays stable
    assign exec_ready = !rd_act;
    assign exec_mode = exec_valid && exec_ready && exec_cmd.sel == `SEL_CTRL
                       && exec_cmd.data[`CW_MODE_DEF];
    assign exec_bsr = exec_valid && exec_ready && exec_cmd.sel == `SEL_CTRL
                      && !exec_cmd.data[`CW_MODE_DEF];
    assign bsr_idx = exec_cmd.data[`BSR_IDX_HI:`BSR_IDX_LO];
    assign bsr_bit = 8'h01 << bsr_idx;
    assign strobed[0] = st_ff.ctrl.a_mode == ppi_pkg::MODE_STROBED;
    assign strobed[1] = st_ff.ctrl.b_mode == ppi_pkg::MODE_STROBED;
    assign is_in[0] = st_ff.ctrl.a_in;
    assign is_in[1] = st_ff.ctrl.b_in;
    // Group A mask sits on bit 4 for input and bit 6 for output
    assign mask_idx_a = is_in[0] ? 3'(`TP_LOAD_A) : 3'(`TP_ACK_A);
    assign stb[0] = is_in[0] ? f.pc[`TP_LOAD_A] : f.pc[`TP_ACK_A];
    assign stb[1] = f.pc[`TP_LOAD_B];

    cmd_fifo #(
        .WIDTH(10),
        .DEPTH(`FIFO_DEPTH)
    ) u_cmd_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .in_data(st_ff.wcmd),
        .in_valid(wr_rise),
        .in_ready(fifo_in_ready),
        .out_data(exec_cmd),
        .out_valid(exec_valid),
        .out_ready(exec_ready)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        nxt_st = st_ff;
        // Three stage synchroniser, a change counts once stages two and three agree
        nxt_st.s1 = pin_vec;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.filt = (~(st_ff.s2 ^ st_ff.s3) & st_ff.s3) | ((st_ff.s2 ^ st_ff.s3) & st_ff.filt);
        nxt_st.prev = st_ff.filt;
        // Host strobes, address decode
        if (!f.cs_n && !f.wr_n) begin
            nxt_st.wr_live = 1'b1;
            nxt_st.wcmd = '{sel: f.sel, data: f.data};
        end else if (wr_rise) begin
            nxt_st.wr_live = 1'b0;
        end
        if (rd_fall) begin
            nxt_st.rd_sel = f.sel;
        end
        // Handshake groups; group index equals the data port select code
        for (int g = 0; g < 2; g++) begin
            if (strobed[g] && is_in[g]) begin
                if (rd_rise && st_ff.rd_sel == 2'(g)) begin
                    nxt_st.grp[g].full = 1'b0;
                end
                if (!stb[g]) begin
                    nxt_st.grp[g].full = 1'b1;
                    nxt_st.grp[g].latch_in = (g == 0) ? f.pa : f.pb;
                end
                if (rd_fall && f.sel == 2'(g)) begin
                    nxt_st.grp[g].irq = 1'b0;
                end
                if (stb[g] && nxt_st.grp[g].full && st_ff.grp[g].mask && !(rd_act && f.sel == 2'(g))) begin
                    nxt_st.grp[g].irq = 1'b1;
                end
            end else if (strobed[g]) begin
                if (!stb[g]) begin
                    nxt_st.grp[g].full = 1'b0;
                end
                if (wr_fall && f.sel == 2'(g)) begin
                    nxt_st.grp[g].irq = 1'b0;
                end
                // Full is set only when the queued write executes, so hold off until the queue drains
                if (stb[g] && !st_ff.grp[g].full && st_ff.grp[g].mask && !wr_rise && !exec_valid
                    && !(!f.cs_n && !f.wr_n && f.sel == 2'(g))) begin
                    nxt_st.grp[g].irq = 1'b1;
                end
            end
        end
        // Buffered writes executed in order
        if (exec_valid && exec_ready) begin
            unique case (exec_cmd.sel)
                `SEL_FIRST: begin
                    nxt_st.pa_latch = exec_cmd.data;
                    if (strobed[0] && !is_in[0]) begin
                        nxt_st.grp[0].full = 1'b1;
                    end
                end
                `SEL_SECOND: begin
                    nxt_st.pb_latch = exec_cmd.data;
                    if (strobed[1] && !is_in[1]) begin
                        nxt_st.grp[1].full = 1'b1;
                    end
                end
                `SEL_THIRD: begin
                    nxt_st.pc_latch = exec_cmd.data;
                end
                `SEL_CTRL: begin
                    if (exec_cmd.data[`CW_MODE_DEF]) begin
                        nxt_st.ctrl.a_mode = (exec_cmd.data[`CW_A_MODE_HI:`CW_A_MODE_LO] != 2'b00)
                                             ? ppi_pkg::MODE_STROBED : ppi_pkg::MODE_BASIC;
                        nxt_st.ctrl.a_in = exec_cmd.data[`CW_A_IN];
                        nxt_st.ctrl.cu_in = exec_cmd.data[`CW_CU_IN];
                        nxt_st.ctrl.b_mode = exec_cmd.data[`CW_B_MODE]
                                             ? ppi_pkg::MODE_STROBED : ppi_pkg::MODE_BASIC;
                        nxt_st.ctrl.b_in = exec_cmd.data[`CW_B_IN];
                        nxt_st.ctrl.cl_in = exec_cmd.data[`CW_CL_IN];
                        nxt_st.pa_latch = `BYTE_ZERO;
                        nxt_st.pb_latch = `BYTE_ZERO;
                        nxt_st.pc_latch = `BYTE_ZERO;
                        nxt_st.grp = '0;
                    end else begin
                        nxt_st.pc_latch[bsr_idx] = exec_cmd.data[`BSR_VAL];
                        if (bsr_idx == mask_idx_a) begin
                            nxt_st.grp[0].mask = exec_cmd.data[`BSR_VAL];
                        end
                        if (bsr_idx == 3'(`TP_LOAD_B)) begin
                            nxt_st.grp[1].mask = exec_cmd.data[`BSR_VAL];
                        end
                    end
                end
            endcase
        end
        // Pin drivers follow the new state
        nxt_st.pa_drv.val = nxt_st.pa_latch;
        nxt_st.pa_drv.oe_n = {8{nxt_st.ctrl.a_in}};
        nxt_st.pb_drv.val = nxt_st.pb_latch;
        nxt_st.pb_drv.oe_n = {8{nxt_st.ctrl.b_in}};
        nxt_st.pc_drv.val = nxt_st.pc_latch;
        nxt_st.pc_drv.oe_n = {{4{nxt_st.ctrl.cu_in}}, {4{nxt_st.ctrl.cl_in}}};
        if (nxt_st.ctrl.a_mode == ppi_pkg::MODE_STROBED) begin
            nxt_st.pc_drv.val[`TP_IRQ_A] = nxt_st.grp[0].irq && nxt_st.grp[0].mask;
            nxt_st.pc_drv.oe_n[`TP_IRQ_A] = 1'b0;
            if (nxt_st.ctrl.a_in) begin
                nxt_st.pc_drv.oe_n[`TP_LOAD_A] = 1'b1;
                nxt_st.pc_drv.val[`TP_INFULL_A] = nxt_st.grp[0].full;
                nxt_st.pc_drv.oe_n[`TP_INFULL_A] = 1'b0;
            end else begin
                nxt_st.pc_drv.oe_n[`TP_ACK_A] = 1'b1;
                nxt_st.pc_drv.val[`TP_OUTFULL_A] = !nxt_st.grp[0].full;
                nxt_st.pc_drv.oe_n[`TP_OUTFULL_A] = 1'b0;
            end
        end
        if (nxt_st.ctrl.b_mode == ppi_pkg::MODE_STROBED) begin
            nxt_st.pc_drv.val[`TP_IRQ_B] = nxt_st.grp[1].irq && nxt_st.grp[1].mask;
            nxt_st.pc_drv.oe_n[`TP_IRQ_B] = 1'b0;
            nxt_st.pc_drv.val[`TP_FLAG_B] = nxt_st.ctrl.b_in ? nxt_st.grp[1].full : !nxt_st.grp[1].full;
            nxt_st.pc_drv.oe_n[`TP_FLAG_B] = 1'b0;
            nxt_st.pc_drv.oe_n[`TP_LOAD_B] = 1'b1;
        end
        // Read path
        unique case (f.sel)
            `SEL_FIRST: begin
                nxt_st.bus_out = !is_in[0] ? st_ff.pa_latch : (strobed[0] ? st_ff.grp[0].latch_in : f.pa);
            end
            `SEL_SECOND: begin
                nxt_st.bus_out = !is_in[1] ? st_ff.pb_latch : (strobed[1] ? st_ff.grp[1].latch_in : f.pb);
            end
            `SEL_THIRD: begin
                // Input bits pass unlatched, driven bits read back their own value
                nxt_st.bus_out = (st_ff.pc_drv.val & ~st_ff.pc_drv.oe_n) | (f.pc & st_ff.pc_drv.oe_n);
            end
            `SEL_CTRL: begin
                nxt_st.bus_out = `BYTE_ZERO;
            end
        endcase
        nxt_st.bus_oe_n = !(rd_act && f.sel != `SEL_CTRL);
        // A write arriving while the buffer is full is dropped
        nxt_st.fifo_full = !fifo_in_ready;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= RESET_ST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign host_bus_lines_out = st_ff.bus_out;
    assign host_bus_lines_oe_n = st_ff.bus_oe_n;
    assign first_port_lines_out = st_ff.pa_drv.val;
    assign first_port_lines_oe_n = st_ff.pa_drv.oe_n;
    assign second_port_lines_out = st_ff.pb_drv.val;
    assign second_port_lines_oe_n = st_ff.pb_drv.oe_n;
    assign third_port_lines_out = st_ff.pc_drv.val;
    assign third_port_lines_oe_n = st_ff.pc_drv.oe_n;
    assign cmd_fifo_full = st_ff.fifo_full;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence s_out_write_a;
        exec_valid && exec_ready && exec_cmd.sel == `SEL_FIRST && strobed[0] && !is_in[0];
    endsequence
    sequence s_out_full_shown;
        st_ff.grp[0].full && !third_port_lines_out[`TP_OUTFULL_A] && !third_port_lines_oe_n[`TP_OUTFULL_A];
    endsequence

    a_ctrl_no_read: assert property (rd_act && f.sel == `SEL_CTRL |=> host_bus_lines_oe_n)
        else $error("control word location drove the bus");
    a_reset_inputs: assert property (st_ff.ctrl == RESET_ST.ctrl |->
        (&first_port_lines_oe_n && &second_port_lines_oe_n && &third_port_lines_oe_n))
        else $error("port line driven in input mode");
    a_group_dir: assert property (!strobed[0] |->
        (first_port_lines_oe_n == {8{st_ff.ctrl.a_in}} && third_port_lines_oe_n[7:4] == {4{st_ff.ctrl.cu_in}}))
        else $error("group A direction wrong");
    a_mode_clears: assert property (exec_mode |=>
        (st_ff.grp == '0 && st_ff.pa_latch == `BYTE_ZERO && st_ff.pc_latch == `BYTE_ZERO))
        else $error("mode write left outputs or flags");
    a_bit_write: assert property (exec_bsr |=>
        (st_ff.pc_latch[$past(bsr_idx)] == $past(exec_cmd.data[`BSR_VAL])
         && ((st_ff.pc_latch ^ $past(st_ff.pc_latch)) & ~$past(bsr_bit)) == `BYTE_ZERO))
        else $error("bit write disturbed other bits");
    a_basic_read: assert property (rd_act && f.sel == `SEL_FIRST && !strobed[0] && is_in[0] |=>
        host_bus_lines_out == $past(f.pa))
        else $error("basic input read not direct");
    a_mask_gate: assert property (strobed[0] && !st_ff.grp[0].mask |->
        !third_port_lines_out[`TP_IRQ_A])
        else $error("request shown while masked");
    a_load_latch: assert property (strobed[0] && is_in[0] && !stb[0] && !exec_mode |=>
        (st_ff.grp[0].full && st_ff.grp[0].latch_in == $past(f.pa)))
        else $error("load strobe did not latch");
    a_read_clear: assert property (rd_fall && f.sel == `SEL_FIRST && strobed[0] && is_in[0] |=>
        !st_ff.grp[0].irq)
        else $error("read fall left request set");
    a_out_full: assert property (s_out_write_a |=> s_out_full_shown)
        else $error("output full not shown after write");
    a_bus_float: assert property (!rd_act |=> host_bus_lines_oe_n)
        else $error("bus driven outside a read");
endmodule

// file: tb/ppi_peer.sv
`timescale 1ns/1ps

module ppi_peer (
    // Clock
    input wire logic mclk,
    // Device drive, first port on top, third port at the bottom
    input wire logic [23:0] dev_out,
    input wire logic [23:0] dev_oe_n,
    // Resolved line levels
    output logic [23:0] lines
);
    logic [23:0] val;
    logic [23:0] drv;
    logic [23:0] flt;

    initial begin
        val = 24'hA6_0054;
        drv = 24'hFF_0054;
        flt = 24'h00_0000;
    end

    // Undriven lines toggle so a stale value never looks valid
    always @(posedge mclk) begin
        flt <= ~flt;
    end

    assign lines = (~dev_oe_n & dev_out) | (dev_oe_n & drv & val) | (dev_oe_n & ~drv & flt);

    // Low pulse, well above the sync filter length
    task strobe(input int b);
        @(posedge mclk);
        #1 val[b] = 1'b0;
        repeat (6) @(posedge mclk);
        #1 val[b] = 1'b1;
    endtask
endmodule

// file: tb/programmable_parallel_port_bench.sv
`timescale 1ns/1ps
`include "ppi_defines.svh"

module programmable_parallel_port_bench;
    logic mclk, nrst, cs_n, rd_n, wr_n, hb_oe_n, ff, oe;
    logic [1:0] sel;
    logic [7:0] hb_in, hb_out, d;
    logic [23:0] dout, doe_n, lines;
    int failures, num_checks;

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    programmable_parallel_port u_programmable_parallel_port (
        .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .port_select_lines(sel),
        .host_bus_lines_in(hb_in), .host_bus_lines_out(hb_out), .host_bus_lines_oe_n(hb_oe_n),
        .first_port_lines_in(lines[23:16]), .first_port_lines_out(dout[23:16]),
        .first_port_lines_oe_n(doe_n[23:16]), .second_port_lines_in(lines[15:8]),
        .second_port_lines_out(dout[15:8]), .second_port_lines_oe_n(doe_n[15:8]),
        .third_port_lines_in(lines[7:0]), .third_port_lines_out(dout[7:0]),
        .third_port_lines_oe_n(doe_n[7:0]), .cmd_fifo_full(ff));

    ppi_peer u_ppi_peer (.mclk(mclk), .dev_out(dout), .dev_oe_n(doe_n), .lines(lines));

    ////////////////////////////////////////////////////////////////////////////////

    task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Data held well past the rise, since the pins reach the core late
    task wr(input logic [1:0] a, input logic [7:0] v);
        step(1);
        sel = a;
        hb_in = v;
        cs_n = 1'b0;
        wr_n = 1'b0;
        step(6);
        wr_n = 1'b1;
        step(5);
        cs_n = 1'b1;
        step(10);
    endtask

    task rd(input logic [1:0] a);
        step(1);
        sel = a;
        cs_n = 1'b0;
        rd_n = 1'b0;
        step(6);
        d = hb_out;
        oe = hb_oe_n;
        rd_n = 1'b1;
        step(1);
        cs_n = 1'b1;
        step(10);
    endtask

    task close_out;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        #2000000;
        failures++;
        close_out;
    end

    initial begin
        nrst = 1'b0;
        {cs_n, rd_n, wr_n} = 3'b111;
        sel = 2'b00;
        hb_in = 8'h00;
        step(4);
        chk("port oe in reset", 24'hFF_FFFF, doe_n);
        nrst = 1'b1;
        step(6);
        chk("bus oe idle", 24'h00_0001, {23'h0, hb_oe_n});
        rd(`SEL_FIRST);
        chk("first read after reset", 24'h00_00A6, {16'h0, d});
        chk("bus oe on read", 24'h00_0000, {23'h0, oe});
        rd(`SEL_CTRL);
        chk("bus oe on control read", 24'h00_0001, {23'h0, oe});
        wr(`SEL_CTRL, 8'h80);
        wr(`SEL_FIRST, 8'h5A);
        wr(`SEL_SECOND, 8'hA5);
        wr(`SEL_THIRD, 8'h3C);
        chk("basic outputs", 24'h5A_A53C, dout);
        wr(`SEL_CTRL, 8'h0D);
        wr(`SEL_CTRL, 8'h04);
        chk("third after bit writes", 24'h00_0078, {16'h0, dout[7:0]});
        for (int i = 0; i < 16; i++) begin
            wr(`SEL_CTRL, {3'b100, i[3], i[2], 1'b0, i[1], i[0]});
            chk("basic direction", {{8{i[3]}}, {8{i[1]}}, {4{i[2]}}, {4{i[0]}}}, doe_n);
            chk("outputs after mode", 24'h00_0000, dout);
        end
        wr(`SEL_CTRL, 8'hB0);
        u_ppi_peer.val[23:16] = 8'hC3;
        u_ppi_peer.strobe(4);
        step(6);
        u_ppi_peer.val[23:16] = 8'h3C;
        chk("in full, masked", 24'h00_0002, {22'h0, dout[5], dout[3]});
        wr(`SEL_CTRL, 8'h09);
        chk("in request", 24'h00_0003, {22'h0, dout[5], dout[3]});
        rd(`SEL_FIRST);
        chk("latched input", 24'h00_00C3, {16'h0, d});
        chk("in flags after read", 24'h00_0000, {22'h0, dout[5], dout[3]});
        wr(`SEL_CTRL, 8'hB0);
        u_ppi_peer.strobe(4);
        step(6);
        chk("mask cleared by mode", 24'h00_0002, {22'h0, dout[5], dout[3]});
        wr(`SEL_CTRL, 8'h84);
        wr(`SEL_CTRL, 8'h05);
        chk("out request when empty", 24'h00_0003, {22'h0, dout[1], dout[0]});
        wr(`SEL_SECOND, 8'h77);
        chk("out full low", 24'h00_7700, {8'h0, dout[15:8], 6'h0, dout[1], dout[0]});
        u_ppi_peer.strobe(2);
        step(6);
        chk("ack then request", 24'h00_0003, {22'h0, dout[1], dout[0]});
        wr(`SEL_SECOND, 8'h88);
        chk("request cleared by write", 24'h00_0000, {22'h0, dout[1], dout[0]});
        wr(`SEL_CTRL, 8'hA0);
        wr(`SEL_CTRL, 8'h0D);
        chk("first out request empty", 24'h00_0003, {22'h0, dout[7], dout[3]});
        wr(`SEL_FIRST, 8'h11);
        chk("first out full", 24'h00_0000, {22'h0, dout[7], dout[3]});
        u_ppi_peer.strobe(6);
        step(6);
        chk("first out request", 24'h00_0003, {22'h0, dout[7], dout[3]});
        chk("write buffer not full", 24'h00_0000, {23'h0, ff});
        close_out;
    end
endmodule
